// >>> flash_host_pkg.sv
/*
 * Constants for the flash bank-mode host controller: APB register map,
 * status fields, command codes and addresses, strobe timing.
 * Assumes a 100 MHz system clock and a 16-bit word-mode flash bus.
 */
package flash_host_pkg;

    // Clock and strobe timing
    localparam int CLK_PERIOD_NS = 10;     // 100 MHz
    localparam int T_AS_NS = 10;           // Address setup before write strobe falls
    localparam int T_WP_NS = 35;           // Write strobe low width
    localparam int T_WH_NS = 20;           // Data and chip enable hold after strobe rises
    localparam int T_ACC_NS = 70;          // Read access time
    localparam int CNT_W = 4;
    // Least times, rounded up to whole cycles
    localparam logic [CNT_W-1:0] CYC_AS = CNT_W'((T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_WP = CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_WH = CNT_W'((T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_ACC = CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CYC_SYNC = 4'h2;  // Pin synchroniser latency
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // Flash bus widths
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int TIMEOUT_BIT = 5;        // Position of timeout_error_flag on the data bus

    // Command cycles
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
    localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00AA;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002AA;
    localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
    localparam logic [ADDR_W-1:0] QUERY_ADDR = 22'h000055;
    localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;
    localparam logic [ADDR_W-1:0] BANK_ADDR_MASK = 22'h3C0000;  // Bank bits of an address

    // APB register byte offsets
    localparam int PADDR_W = 8;
    localparam logic [PADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [PADDR_W-1:0] REG_ADDR = 8'h04;
    localparam logic [PADDR_W-1:0] REG_WDATA = 8'h08;
    localparam logic [PADDR_W-1:0] REG_RDATA = 8'h0C;
    localparam logic [PADDR_W-1:0] REG_STATUS = 8'h10;

    // Field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int OP_W = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_READY = 1;
    localparam int ST_TIMEOUT = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_MODE_LSB = 4;

    // Operations written into the control register
    typedef enum logic [OP_W-1:0] {
        OP_WRITE = 3'h0,
        OP_READ = 3'h1,
        OP_RESET = 3'h2,
        OP_AUTOSEL = 3'h3,
        OP_QUERY = 3'h4
    } op_t;

    // Host's view of the addressed bank's mode
    typedef enum logic [1:0] {
        MODE_ARRAY = 2'h0,
        MODE_AUTOSEL = 2'h1,
        MODE_QUERY = 2'h2
    } mode_t;

endpackage

// >>> sync2.sv
/*
 * Two-flop synchroniser for a bus of independent level inputs.
 * Assumes each bit is sampled on its own; no bus coherence is promised.
 */
module sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Levels
    input wire logic [WIDTH-1:0] in_async,
    output logic [WIDTH-1:0] out_sync
);

    logic [WIDTH-1:0] meta_q;  // First stage, read only by the second

    // Both stages shift together
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            out_sync <= '0;
        end else begin
            meta_q <= in_async;
            out_sync <= meta_q;
        end
    end

endmodule

// >>> flash_host_ctrl.sv
/*
 * Host controller for a multi-bank parallel NOR flash: APB slave for
 * software, driving chip enable, write and output strobes, address and data.
 * Assumes the flash answers asynchronously; pin inputs are synchronised.
 */
module flash_host_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flash_host_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash pins
    output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
    output logic [flash_host_pkg::DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe,
    input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i,
    output logic flash_ce_b,
    output logic flash_we_b,
    output logic flash_oe_b,
    input wire logic ready_busy_out
);

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_RWAIT, ST_RSYNC} st_t;

    localparam int AW = flash_host_pkg::ADDR_W;
    localparam int DW = flash_host_pkg::DATA_W;
    localparam int ST_BUSY_IDX = flash_host_pkg::ST_BUSY;
    localparam int ST_READY_IDX = flash_host_pkg::ST_READY;
    localparam int ST_TIMEOUT_IDX = flash_host_pkg::ST_TIMEOUT;
    localparam int ST_REFUSED_IDX = flash_host_pkg::ST_REFUSED;
    localparam int ST_MODE_IDX = flash_host_pkg::ST_MODE_LSB;
    localparam int OP_W_L = flash_host_pkg::OP_W;
    localparam logic [flash_host_pkg::CNT_W-1:0] CNT_ONE_L = flash_host_pkg::CNT_ONE;

    // Synchronised pins
    logic [DW-1:0] dq_s;
    logic rb_s;  // High when flash is ready

    // Sequencer state
    st_t state_q, state_d;
    logic [flash_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] idx_q, idx_d;  // Cycle within a command sequence
    flash_host_pkg::op_t op_q, op_d;
    // Software registers
    logic [AW-1:0] addr_reg_q, addr_reg_d;
    logic [DW-1:0] wdata_q, wdata_d;
    logic [DW-1:0] rdata_q, rdata_d;
    logic timeout_q, timeout_d;
    logic refused_q, refused_d;
    flash_host_pkg::mode_t mode_q, mode_d;
    // APB read path
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    // Pin registers
    logic [AW-1:0] fa_q, fa_d;
    logic [DW-1:0] fdo_q, fdo_d;
    logic fdoe_q, fdoe_d;
    logic ce_b_q, ce_b_d;
    logic we_b_q, we_b_d;
    logic oe_b_q, oe_b_d;

    // Decoded bus traffic
    logic wr_acc, setup_rd, go;
    logic [1:0] last_idx;
    logic [AW+DW-1:0] cyc;

    sync2 #(.WIDTH(DW)) u_sync_dq (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_async(flash_dq_i),
        .out_sync(dq_s)
    );

    sync2 #(.WIDTH(1)) u_sync_rb (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_async(ready_busy_out),
        .out_sync(rb_s)
    );

    // Address and data of each command cycle, plain writes included
    function automatic logic [AW+DW-1:0] cycle_of(flash_host_pkg::op_t op, logic [1:0] idx,
                                                   logic [AW-1:0] a, logic [DW-1:0] d);
        logic [AW+DW-1:0] r;
        r = {a, d};
        unique case (op)
            flash_host_pkg::OP_RESET: r = {a, flash_host_pkg::CMD_RESET};
            flash_host_pkg::OP_QUERY:
                r = {flash_host_pkg::QUERY_ADDR, flash_host_pkg::CMD_QUERY};
            flash_host_pkg::OP_AUTOSEL: begin
                if (idx == 2'h0) begin
                    r = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
                end else if (idx == 2'h1) begin
                    r = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA};
                end else begin
                    // Bank bits from software, low bits from the unlock address
                    r = {(a & flash_host_pkg::BANK_ADDR_MASK) | flash_host_pkg::UNLOCK1_ADDR,
                         flash_host_pkg::CMD_AUTOSEL};
                end
            end
            default: r = {a, d};  // Plain write cycle; reads also fall here but never reach ST_SETUP
        endcase
        return r;
    endfunction

    assign wr_acc = psel && penable && pwrite;
    assign setup_rd = psel && !penable && !pwrite;
    assign go = wr_acc && (paddr == flash_host_pkg::REG_CTRL) && (state_q == ST_IDLE);
    assign last_idx = (op_q == flash_host_pkg::OP_AUTOSEL) ? 2'h2 : 2'h0;
    assign cyc = cycle_of(op_q, idx_q, addr_reg_q, wdata_q);

    // Zero wait states; read data and error were registered in setup
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign flash_addr = fa_q;
    assign flash_dq_o = fdo_q;
    assign flash_dq_oe = fdoe_q;
    assign flash_ce_b = ce_b_q;
    assign flash_we_b = we_b_q;
    assign flash_oe_b = oe_b_q;

    // APB register file next values
    always_comb begin
        addr_reg_d = addr_reg_q;
        wdata_d = wdata_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (wr_acc && paddr == flash_host_pkg::REG_ADDR) begin
            addr_reg_d = pwdata[AW-1:0];  // Bank and sector address for reads
        end
        if (wr_acc && paddr == flash_host_pkg::REG_WDATA) begin
            wdata_d = pwdata[DW-1:0];
        end
        if (psel && !penable) begin
            // Decide the answer in setup so the access phase needs no wait
            unique case (paddr)
                flash_host_pkg::REG_CTRL, flash_host_pkg::REG_ADDR,
                flash_host_pkg::REG_WDATA, flash_host_pkg::REG_RDATA,
                flash_host_pkg::REG_STATUS: pslverr_d = 1'b0;
                default: pslverr_d = 1'b1;  // Unmapped offset
            endcase
        end
        if (setup_rd) begin
            unique case (paddr)
                flash_host_pkg::REG_CTRL: prdata_d = {29'h0, op_q};
                flash_host_pkg::REG_ADDR: prdata_d = {10'h0, addr_reg_q};
                flash_host_pkg::REG_WDATA: prdata_d = {16'h0, wdata_q};
                flash_host_pkg::REG_RDATA: prdata_d = {16'h0, rdata_q};
                flash_host_pkg::REG_STATUS: begin
                    prdata_d = 32'h0;
                    prdata_d[ST_BUSY_IDX] = (state_q != ST_IDLE);
                    prdata_d[ST_READY_IDX] = rb_s;
                    prdata_d[ST_TIMEOUT_IDX] = timeout_q;
                    prdata_d[ST_REFUSED_IDX] = refused_q;
                    prdata_d[ST_MODE_IDX +: 2] = mode_q;
                end
                default: prdata_d = 32'h0;
            endcase
        end
    end

    // Sequencer and pin next values
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        op_d = op_q;
        rdata_d = rdata_q;
        timeout_d = timeout_q;
        refused_d = refused_q;
        mode_d = mode_q;
        fa_d = fa_q;
        fdo_d = fdo_q;
        fdoe_d = fdoe_q;
        ce_b_d = ce_b_q;
        we_b_d = we_b_q;
        oe_b_d = oe_b_q;
        // Software clears the refusal by writing one; a new refusal wins
        if (wr_acc && paddr == flash_host_pkg::REG_STATUS && pwdata[ST_REFUSED_IDX]) begin
            refused_d = 1'b0;
        end
        unique case (state_q)
            ST_IDLE: begin
                if (go) begin
                    op_d = flash_host_pkg::op_t'(pwdata[flash_host_pkg::CTRL_OP_LSB +: OP_W_L]);
                    idx_d = 2'h0;
                    unique case (flash_host_pkg::op_t'(pwdata[flash_host_pkg::CTRL_OP_LSB +: OP_W_L]))
                        flash_host_pkg::OP_READ: begin
                            // Array, autoselect or query read
                            fa_d = addr_reg_q;
                            ce_b_d = 1'b0;
                            oe_b_d = 1'b0;
                            cnt_d = flash_host_pkg::CYC_ACC;
                            state_d = ST_RWAIT;
                        end
                        flash_host_pkg::OP_AUTOSEL: begin
                            if (!rb_s || mode_q != flash_host_pkg::MODE_ARRAY) begin
                                refused_d = 1'b1;
                            end else begin
                                state_d = ST_SETUP;
                                cnt_d = flash_host_pkg::CYC_AS;
                            end
                        end
                        flash_host_pkg::OP_QUERY: begin
                            // Only while the flash can read array or autoselect data
                            if (!rb_s || mode_q == flash_host_pkg::MODE_QUERY) begin
                                refused_d = 1'b1;
                            end else begin
                                state_d = ST_SETUP;
                                cnt_d = flash_host_pkg::CYC_AS;
                            end
                        end
                        flash_host_pkg::OP_WRITE, flash_host_pkg::OP_RESET: begin
                            state_d = ST_SETUP;
                            cnt_d = flash_host_pkg::CYC_AS;
                        end
                        default: refused_d = 1'b1;  // Undefined code never reaches the pins
                    endcase
                end
            end
            ST_SETUP: begin
                // Address, data and chip enable change on the same edge as the write strobe falls
                fa_d = cyc[AW+DW-1:DW];
                fdo_d = cyc[DW-1:0];
                fdoe_d = 1'b1;
                ce_b_d = 1'b0;
                cnt_d = cnt_q - CNT_ONE_L;
                if (cnt_q == flash_host_pkg::CNT_ONE) begin
                    we_b_d = 1'b0;
                    cnt_d = flash_host_pkg::CYC_WP;
                    state_d = ST_PULSE;
                end
            end
            ST_PULSE: begin
                cnt_d = cnt_q - CNT_ONE_L;
                if (cnt_q == flash_host_pkg::CNT_ONE) begin
                    we_b_d = 1'b1;  // Write strobe rises first, latching data
                    cnt_d = flash_host_pkg::CYC_WH;
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                cnt_d = cnt_q - CNT_ONE_L;
                if (cnt_q == flash_host_pkg::CNT_ONE) begin
                    // Chip enable rises a cycle before the next setup
                    ce_b_d = 1'b1;
                    fdoe_d = 1'b0;
                    if (idx_q == last_idx) begin
                        state_d = ST_IDLE;
                        unique case (op_q)
                            flash_host_pkg::OP_RESET: begin
                                mode_d = flash_host_pkg::MODE_ARRAY;
                                timeout_d = 1'b0;
                            end
                            flash_host_pkg::OP_AUTOSEL: mode_d = flash_host_pkg::MODE_AUTOSEL;
                            flash_host_pkg::OP_QUERY: mode_d = flash_host_pkg::MODE_QUERY;
                            default: mode_d = mode_q;  // Plain writes keep the mode
                        endcase
                    end else begin
                        idx_d = idx_q + 2'h1;
                        cnt_d = flash_host_pkg::CYC_AS;
                        state_d = ST_SETUP;
                    end
                end
            end
            ST_RWAIT: begin
                cnt_d = cnt_q - CNT_ONE_L;
                if (cnt_q == flash_host_pkg::CNT_ONE) begin
                    cnt_d = flash_host_pkg::CYC_SYNC;
                    state_d = ST_RSYNC;
                end
            end
            ST_RSYNC: begin
                // Data stays driven until the synchroniser has caught it
                cnt_d = cnt_q - CNT_ONE_L;
                if (cnt_q == flash_host_pkg::CNT_ONE) begin
                    rdata_d = dq_s;
                    if (!rb_s && dq_s[flash_host_pkg::TIMEOUT_BIT]) begin
                        timeout_d = 1'b1;
                    end
                    ce_b_d = 1'b1;
                    oe_b_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Registers; flash starts in array read, so mode resets to it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            idx_q <= 2'h0;
            op_q <= flash_host_pkg::OP_WRITE;
            addr_reg_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            timeout_q <= 1'b0;
            refused_q <= 1'b0;
            mode_q <= flash_host_pkg::MODE_ARRAY;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
            fa_q <= '0;
            fdo_q <= '0;
            fdoe_q <= 1'b0;
            ce_b_q <= 1'b1;
            we_b_q <= 1'b1;
            oe_b_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            op_q <= op_d;
            addr_reg_q <= addr_reg_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            timeout_q <= timeout_d;
            refused_q <= refused_d;
            mode_q <= mode_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            fa_q <= fa_d;
            fdo_q <= fdo_d;
            fdoe_q <= fdoe_d;
            ce_b_q <= ce_b_d;
            we_b_q <= we_b_d;
            oe_b_q <= oe_b_d;
        end
    end

endmodule

// >>> flash_host_ctrl_props.sv
/*
 * Strobe and command checks for the flash host controller.
 * Bound to flash_host_ctrl; sees its ports only.
 */
module flash_host_ctrl_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Flash pins
    input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_o,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_b,
    input wire logic flash_we_b,
    input wire logic flash_oe_b,
    input wire logic ready_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    AST_IDLE_AFTER_RESET: assert property ($rose(rst_b) |-> flash_ce_b && flash_we_b
        && flash_oe_b && !flash_dq_oe) else $error("strobes busy after reset");
    AST_WE_NEEDS_CE: assert property (!flash_we_b |-> !flash_ce_b && flash_oe_b
        && flash_dq_oe) else $error("write strobe without chip enable");
    AST_NO_CONTENTION: assert property (!flash_oe_b |-> !flash_dq_oe && flash_we_b)
        else $error("host drives data during a read");
    AST_ADDR_STABLE: assert property (!flash_ce_b && $past(!flash_ce_b)
        |-> $stable(flash_addr)) else $error("address moved inside a cycle");
    AST_DATA_STABLE: assert property (flash_dq_oe && $past(flash_dq_oe)
        |-> $stable(flash_dq_o)) else $error("data moved inside a write");
    AST_WE_WIDTH: assert property ($fell(flash_we_b) |-> !flash_we_b[*4] ##1 flash_we_b)
        else $error("write strobe width wrong");
    AST_WE_HOLD: assert property ($rose(flash_we_b) |-> !flash_ce_b[*2] ##1 flash_ce_b)
        else $error("chip enable hold wrong");
    AST_QUERY_ADDR: assert property ($fell(flash_we_b) && flash_dq_o == 16'h0098
        |-> flash_addr == 22'h000055) else $error("query command at wrong address");
    AST_AUTOSEL_CMD: assert property ($fell(flash_we_b) && flash_dq_o == 16'h0090
        |-> flash_addr[17:0] == 18'h00555 && ready_busy_out)
        else $error("autoselect command misplaced");
endmodule

// >>> flash_model.sv
/*
 * Behavioural model of the flash: command decoding, query table, autoselect.
 * Assumes word mode, one bank view, a four-bank bottom-boot variant.
 */
module flash_model #(
    parameter logic [15:0] AUTO_CODE = 16'h00C3  // Arbitrary value
) (
    // Host pins
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    input wire logic flash_ce_b,
    input wire logic flash_we_b,
    input wire logic flash_oe_b,
    output logic [15:0] flash_dq_i,
    output logic ready_busy_out,
    // Raise to fake a timeout
    input wire logic fault
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [1:0] {ARRAY, AUTO, QUERY} fmode_t;
    // Extended table, 40h..50h then 57h..5Bh
    localparam logic [7:0] QT [22] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h33, 8'h0C, 8'h02,
        8'h01, 8'h01, 8'h04, 8'h38, 8'h00, 8'h00, 8'h85, 8'h95, 8'h02, 8'h00,
        8'h04, 8'h0F, 8'h18, 8'h18, 8'h08};
    fmode_t mode = ARRAY;  // Powers up reading array
    logic [1:0] seq = 2'h0;  // Unlock cycles seen
    logic stuck = 1'b0;  // Timed out, waiting for reset
    logic [21:0] lat_a = 22'h0;  // Latched address
    logic [15:0] last = 16'h0;  // Last driven value
    logic [15:0] val;  // Value for the current address
    wire wr_act = !flash_ce_b && !flash_we_b && flash_oe_b;

    // Low until reset
    assign ready_busy_out = !stuck;
    always @(posedge fault) stuck = 1'b1;

    function automatic logic [15:0] qt(input logic [7:0] a);
        if (a >= 8'h40 && a <= 8'h50) return {8'h00, QT[int'(a) - 64]};
        if (a >= 8'h57 && a <= 8'h5B) return {8'h00, QT[int'(a) - 70]};
        return 16'h0000;
    endfunction

    // Address on the later falling strobe
    always @(posedge wr_act) lat_a = flash_addr;
    // Data on the earlier rising strobe
    always @(negedge wr_act) begin
        if (flash_dq_o[7:0] == 8'hF0) begin
            mode = ARRAY;
            seq = 2'h0;
            stuck = 1'b0;
        end else if (stuck) begin
            seq = 2'h0;
        end else if (seq == 2'h2 && flash_dq_o[7:0] == 8'h90 && mode == ARRAY) begin
            mode = AUTO;
            seq = 2'h0;
        end else if (seq == 2'h1 && lat_a[10:0] == 11'h2AA && flash_dq_o[7:0] == 8'h55) begin
            seq = 2'h2;
        end else if (lat_a[10:0] == 11'h555 && flash_dq_o[7:0] == 8'hAA) begin
            seq = 2'h1;
        end else if (lat_a[7:0] == 8'h55 && flash_dq_o[7:0] == 8'h98) begin
            mode = QUERY;
            seq = 2'h0;
        end else begin
            seq = 2'h0;  // Malformed sequence dropped
        end
    end

    // Read data by mode
    always @* begin
        if (stuck) val = 16'h0020;  // Timeout flag up
        else if (mode == QUERY) val = qt(flash_addr[7:0]);
        else if (mode == AUTO) val = AUTO_CODE;
        else val = flash_addr[15:0] ^ 16'h5A5A;
    end
    // Released bus shows the inverse, not a stale match
    always @* begin
        if (!flash_ce_b && !flash_oe_b) begin
            flash_dq_i = val;
            last = val;
        end else begin
            flash_dq_i = ~last;
        end
    end
endmodule

// >>> flash_host_ctrl_bench.sv
/*
 * Self-checking bench for the flash host controller over APB.
 * Assumes flash_model on the pins and the checker bound below.
 */
module flash_host_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] AUTO_EXP = 16'h00C3;  // Arbitrary value
    localparam logic [32:0] SM = 33'h1_0000_003F;  // Status compare mask
    localparam logic [7:0] RS = flash_host_pkg::REG_STATUS;
    logic clk_sys;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [21:0] flash_addr;
    logic [15:0] flash_dq_o;
    logic flash_dq_oe;
    logic [15:0] flash_dq_i;
    logic flash_ce_b;
    logic flash_we_b;
    logic flash_oe_b;
    logic ready_busy_out;
    logic fault = 1'b0;
    logic [32:0] exp_q[$];  // Expected {pslverr, prdata}
    logic [32:0] msk_q[$];
    logic [31:0] seed = 32'h0A51;
    logic [7:0] qv [22] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h33, 8'h0C, 8'h02, 8'h01, 8'h01,
        8'h04, 8'h38, 8'h00, 8'h00, 8'h85, 8'h95, 8'h02, 8'h00, 8'h04, 8'h0F, 8'h18, 8'h18, 8'h08};
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;

    flash_host_ctrl i_flash_host_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .flash_ce_b(flash_ce_b),
        .flash_we_b(flash_we_b), .flash_oe_b(flash_oe_b), .ready_busy_out(ready_busy_out));
    flash_model #(.AUTO_CODE(AUTO_EXP)) i_flash_model (.flash_addr(flash_addr),
        .flash_dq_o(flash_dq_o), .flash_ce_b(flash_ce_b), .flash_we_b(flash_we_b),
        .flash_oe_b(flash_oe_b), .flash_dq_i(flash_dq_i), .ready_busy_out(ready_busy_out),
        .fault(fault));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task complete_run;
        if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            complete_run();
        end
    end

    // Watcher: a finished read takes the oldest note
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            n_tests++;
            if ((({pslverr, prdata} ^ exp_q[0]) & msk_q[0]) !== 33'h0) begin
                miscompares++;
                $display("wrong value at %0t: got %h expected %h", $time, {pslverr, prdata},
                    exp_q[0]);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task st(input logic [1:0] m, input logic rf, to, rdy);
        rd(RS, {27'h0, m, rf, to, rdy, 1'b0}, SM);
    endtask

    // One APB transfer, held until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    // Start an op, poll until idle
    task op(input logic [2:0] c, input logic [21:0] a);
        apb(1'b1, flash_host_pkg::REG_ADDR, 32'(a));
        apb(1'b1, flash_host_pkg::REG_CTRL, 32'(c));
        for (int i = 0; i < 60; i++) begin
            rd(RS, 33'h0, 33'h0);
            if (prdata[0] === 1'b0) break;
        end
    endtask

    task fr(input logic [21:0] a, input logic [15:0] e);
        op(3'h1, a);
        rd(flash_host_pkg::REG_RDATA, {17'h0, e}, 33'h1_0000_FFFF);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        st(2'h0, 1'b0, 1'b0, 1'b1);
        rd(8'h14, 33'h1_0000_0000, 33'h1_0000_0000);
        // Array reads, no command first
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            fr(seed[21:0], seed[15:0] ^ 16'h5A5A);
        end
        op(3'h4, 22'h0);
        st(2'h2, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 22; i++) begin
            fr(22'(i < 17 ? 8'h40 + i : 8'h46 + i), {8'h00, qv[i]});
        end
        op(3'h4, 22'h0);
        st(2'h2, 1'b1, 1'b0, 1'b1);
        apb(1'b1, RS, 32'h8);
        op(3'h2, 22'h0);
        st(2'h0, 1'b0, 1'b0, 1'b1);
        // Autoselect, repeated reads
        op(3'h3, 22'h0C0000);
        st(2'h1, 1'b0, 1'b0, 1'b1);
        fr(22'h0C0000, AUTO_EXP);
        fr(22'h0C0002, AUTO_EXP);
        op(3'h3, 22'h0C0000);
        st(2'h1, 1'b1, 1'b0, 1'b1);
        apb(1'b1, RS, 32'h8);
        op(3'h2, 22'h0C0000);
        fr(22'h0C0004, 16'h5A5E);
        // Timed-out flash and recovery
        fault <= 1'b1;
        repeat (6) @(posedge clk_sys);
        op(3'h3, 22'h0);
        st(2'h0, 1'b1, 1'b0, 1'b0);
        apb(1'b1, RS, 32'h8);
        op(3'h1, 22'h0);
        st(2'h0, 1'b0, 1'b1, 1'b0);
        op(3'h2, 22'h0);
        fault <= 1'b0;
        st(2'h0, 1'b0, 1'b0, 1'b1);
        op(3'h0, 22'h0);
        st(2'h0, 1'b0, 1'b0, 1'b1);
        op(3'h7, 22'h0);
        st(2'h0, 1'b1, 1'b0, 1'b1);
        complete_run();
    end
endmodule

bind flash_host_ctrl flash_host_ctrl_props i_flash_host_ctrl_props (.clk_sys(clk_sys),
    .rst_b(rst_b), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe), .flash_ce_b(flash_ce_b), .flash_we_b(flash_we_b),
    .flash_oe_b(flash_oe_b), .ready_busy_out(ready_busy_out));
